/* verilog/uic_params.svh */
`ifndef UIC_PARAMS_SVH
`define UIC_PARAMS_SVH
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define UIC_CLK_MHZ 100
`define UIC_NS2CYC_UP(ns) ((((ns) * `UIC_CLK_MHZ) + 999) / 1000)
`define UIC_NS2CYC_DN(ns) (((ns) * `UIC_CLK_MHZ) / 1000)
`define UIC_GF1_NS 111
`define UIC_GF2_NS 1780
`define UIC_GF3_NS 14220
`define UIC_GF1_CYC `UIC_NS2CYC_UP(`UIC_GF1_NS)
`define UIC_GF2_CYC `UIC_NS2CYC_UP(`UIC_GF2_NS)
`define UIC_GF3_CYC `UIC_NS2CYC_UP(`UIC_GF3_NS)
`define UIC_TICK_NS 3000
`define UIC_TICK_CYC `UIC_NS2CYC_DN(`UIC_TICK_NS)
`define UIC_TMR_NS 1000
`define UIC_TMR_CYC `UIC_NS2CYC_DN(`UIC_TMR_NS)
`define UIC_MS_NS 1000000
`define UIC_MS_CYC `UIC_NS2CYC_DN(`UIC_MS_NS)
`define UIC_DB1_MS 10
`define UIC_DB2_MS 20
`define UIC_DB3_MS 40
`define UIC_DB4_MS 100
`define UIC_DB5_MS 200
`define UIC_DB6_MS 400
`define UIC_DB7_MS 1000
// ------------------------------------------------------------
// sensor type codes
// ------------------------------------------------------------
`define UIC_T_V5 8'h0c
`define UIC_T_V10 8'h0d
`define UIC_T_I20 8'h14
`define UIC_T_I420 8'h15
`define UIC_T_F0 8'h28
`define UIC_T_F1 8'h29
`define UIC_T_F2 8'h2a
`define UIC_T_P0 8'h32
`define UIC_T_P1 8'h33
`define UIC_T_DN 8'h3c
`define UIC_T_DI 8'h3d
`define UIC_T_DL 8'h3e
`define UIC_T_QD 8'h50
`define UIC_T_SENT 8'h64
// ------------------------------------------------------------
// config word fields, codes, resets
// ------------------------------------------------------------
`define UIC_POL_BIT 15
`define UIC_PULL_UP 2'h1
`define UIC_PULL_DN 2'h2
`define UIC_FT_MOV 2'h1
`define UIC_FT_REP 2'h2
`define UIC_CFG_RST 32'h0000_4000
`define UIC_RNG_RST 32'hffff_0000
`define UIC_QRNG_RST 32'h7fff_8000
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define UIC_IX(a) ((a) >> 2)
`define UIC_A_CFG 8'h00
`define UIC_A_PPR 8'h20
`define UIC_A_RNG 8'h30
`define UIC_A_QRNG 8'h40
`define UIC_A_VAL 8'h50
`define UIC_A_QCNT 8'h60
`define UIC_A_DIG 8'h64
`define UIC_A_FLT 8'h68
`define UIC_A_SENT 8'h70
// ------------------------------------------------------------
// serial nibble frames
// ------------------------------------------------------------
`define UIC_S_SYNC 8'h38
`define UIC_S_NIB0 8'h0c
`define UIC_S_NIBF 8'h1b
`define UIC_S_SEED 4'h5
`define UIC_S_POLY 4'hd
`endif

/* verilog/uic_pkg.sv */
package uic_pkg;
  typedef enum logic [2:0] {md_off, md_ana, md_freq, md_pwm, md_dig, md_sent} uic_mode_t;
  typedef enum logic {st_hunt, st_nib} uic_sent_st_t;
endpackage : uic_pkg

/* verilog/uic_filt_if.sv */
interface uic_filt_if;
  logic valid;
  logic [15:0] din;
  logic [1:0] ftype;
  logic [7:0] fconst;
  logic [15:0] dout;
  modport src (output valid, output din, output ftype, output fconst, input dout);
  modport filt (input valid, input din, input ftype, input fconst, output dout);
endinterface : uic_filt_if

/* verilog/uic_filter.sv */
`include "uic_params.svh"
module uic_filter import uic_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // sample stream
  uic_filt_if.filt f
);
  logic [15:0] val;
  logic [23:0] acc;
  logic [7:0] cnt;
  // a zero constant acts as one so the divider never sees zero
  wire [7:0] n = (f.fconst == 8'h00) ? 8'h01 : f.fconst;
  wire signed [17:0] diff = $signed({2'b00, f.din}) - $signed({2'b00, val});
  wire signed [17:0] step = diff / $signed({10'h000, n});
  wire [17:0] mov = 18'($signed({2'b00, val}) + step);
  wire [23:0] sum = acc + {8'h00, f.din};
  wire last = (cnt + 8'h01) == n;
  wire [23:0] avg = sum / {16'h0000, n};

  assign f.dout = val;

  always_ff @(posedge mclk) begin
    if (srst) begin
      val <= 16'h0000;
      acc <= 24'h000000;
      cnt <= 8'h00;
    end else if (f.valid) begin
      case (f.ftype)
        `UIC_FT_MOV: begin
          val <= mov[15:0];
          acc <= 24'h000000;
          cnt <= 8'h00;
        end
        `UIC_FT_REP: begin
          if (last) begin
            val <= avg[15:0];
            acc <= 24'h000000;
            cnt <= 8'h00;
          end else begin
            acc <= sum;
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          val <= f.din;
          acc <= 24'h000000;
          cnt <= 8'h00;
        end
      endcase
    end
  end
endmodule : uic_filter

/* verilog/uic_top.sv */
// Behaviour
// - sensor-type code picks off, voltage, current, frequency, width, digital or serial mode.
// - voltage and current modes take the 12-bit converter result, no capture.
// - serial nibble decode only on inputs two and four, 3 us tick.
// - frame gives status, two 12-bit signals, received crc shl 8 plus computed crc.
// - digital modes add a 3-bit selectable debounce of 0 to 1000 ms.
// - frequency and width modes feed a 16-bit capture channel.
// - capture glitch filter code: none, 111 ns, 1.78 us, 14.22 us.
// - nonzero pulses-per-rev multiplies the value; zero keeps native units.
// - any digital mode yields a single bit, 1 on, 0 off.
// - normal reads active as 1, inverse as 0, latched toggles on activation.
// - no fault reporting for inputs in digital modes.
// - pull code 0 none, 1 up, 2 down; down after reset; some modes only.
// - polarity bit 0 active high, 1 active low; active high after reset.
// - output saturated to min and max range limits.
// - filter code 0 none, 1 moving, 2 repeating; none after reset.
// - moving average adds difference over constant to previous output.
// - repeating average sums N samples, outputs sum over N, restarts.
// - three pulse pins take digital types, polarity and same debounce.
// - quadrature uses pulse pins one and two, both set to code 80.
// - quadrature value is pulse count bounded by range limits.
`include "uic_params.svh"
module uic_top import uic_pkg::*; #(
  parameter int MS_CYCLES = `UIC_MS_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // converter samples
  input wire logic [47:0] adc_data,
  input wire logic [3:0] adc_valid,
  // sensor pins
  input wire logic [3:0] uin_pin,
  input wire logic [2:0] pulse_pin,
  // pull controls and digital states
  output logic [6:0] pull_up_en,
  output logic [6:0] pull_dn_en,
  output logic [6:0] dig_state
);
  localparam int NCH = 4;
  localparam int NDI = 7;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic uic_mode_t mode_of(input logic [7:0] t, input logic sent_ok);
    case (t)
      `UIC_T_V5, `UIC_T_V10, `UIC_T_I20, `UIC_T_I420: return md_ana;
      `UIC_T_F0, `UIC_T_F1, `UIC_T_F2: return md_freq;
      `UIC_T_P0, `UIC_T_P1: return md_pwm;
      `UIC_T_DN, `UIC_T_DI, `UIC_T_DL: return md_dig;
      `UIC_T_SENT: return sent_ok ? md_sent : md_off;
      default: return md_off;
    endcase
  endfunction : mode_of

  function automatic logic [9:0] db_ms(input logic [2:0] c);
    case (c)
      3'h1: return 10'(`UIC_DB1_MS);
      3'h2: return 10'(`UIC_DB2_MS);
      3'h3: return 10'(`UIC_DB3_MS);
      3'h4: return 10'(`UIC_DB4_MS);
      3'h5: return 10'(`UIC_DB5_MS);
      3'h6: return 10'(`UIC_DB6_MS);
      3'h7: return 10'(`UIC_DB7_MS);
      default: return 10'h000;
    endcase
  endfunction : db_ms

  function automatic logic [10:0] gf_cyc(input logic [1:0] c);
    case (c)
      2'h1: return 11'(`UIC_GF1_CYC);
      2'h2: return 11'(`UIC_GF2_CYC);
      2'h3: return 11'(`UIC_GF3_CYC);
      default: return 11'h000;
    endcase
  endfunction : gf_cyc

  function automatic logic [3:0] crc4(input logic [3:0] c, input logic [3:0] d);
    logic [3:0] r;
    r = c;
    for (int b = 3; b >= 0; b--) begin
      r = {r[2:0], 1'b0} ^ (((r[3] ^ d[b]) == 1'b1) ? `UIC_S_POLY : 4'h0);
    end
    return r;
  endfunction : crc4

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [31:0] m);
    return (o & ~m) | (n & m);
  endfunction : merge

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [31:0] cfg [NDI];
  logic [15:0] ppr [NCH];
  logic [31:0] rng [NCH];
  logic [31:0] qrng;
  logic [31:0] val [NCH];
  logic [NCH-1:0] fault;
  logic signed [15:0] qcnt;
  logic [3:0] s_stat [NCH];
  logic [11:0] s_sig1 [NCH];
  logic [11:0] s_sig2 [NCH];
  logic [15:0] s_crc [NCH];
  logic [NCH-1:0] s_done;
  logic [31:0] rmap [32];

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  wire [4:0] ridx = wb_adr_i[6:2];
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & ~wb_adr_i[7];
  wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // upper half of the map answers zero and drops writes
  wire [31:0] rsel = wb_adr_i[7] ? 32'h0000_0000 : rmap[ridx];

  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req & ~wb_we_i) begin
        wb_dat_o <= rsel;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int k = 0; k < NDI; k++) begin
        cfg[k] <= `UIC_CFG_RST;
      end
      for (int k = 0; k < NCH; k++) begin
        ppr[k] <= 16'h0000;
        rng[k] <= `UIC_RNG_RST;
      end
      qrng <= `UIC_QRNG_RST;
    end else if (wr) begin
      for (int k = 0; k < NDI; k++) begin
        if (ridx == 5'(`UIC_IX(`UIC_A_CFG) + k)) begin
          cfg[k] <= merge(cfg[k], wb_dat_i, bmask);
        end
      end
      for (int k = 0; k < NCH; k++) begin
        if (ridx == 5'(`UIC_IX(`UIC_A_PPR) + k)) begin
          ppr[k] <= 16'(merge({16'h0000, ppr[k]}, wb_dat_i, bmask));
        end
        if (ridx == 5'(`UIC_IX(`UIC_A_RNG) + k)) begin
          rng[k] <= merge(rng[k], wb_dat_i, bmask);
        end
      end
      if (ridx == 5'(`UIC_IX(`UIC_A_QRNG))) begin
        qrng <= merge(qrng, wb_dat_i, bmask);
      end
    end
  end

  // ------------------------------------------------------------
  // read map
  // ------------------------------------------------------------
  for (genvar r = 0; r < 32; r++) begin : g_rmap
    localparam int IC = `UIC_IX(`UIC_A_CFG);
    localparam int IP = `UIC_IX(`UIC_A_PPR);
    localparam int IR = `UIC_IX(`UIC_A_RNG);
    localparam int IV = `UIC_IX(`UIC_A_VAL);
    localparam int IS = `UIC_IX(`UIC_A_SENT);
    if (r >= IC && r < IC + NDI) begin : g_c
      assign rmap[r] = cfg[r - IC];
    end else if (r >= IP && r < IP + NCH) begin : g_p
      assign rmap[r] = {16'h0000, ppr[r - IP]};
    end else if (r >= IR && r < IR + NCH) begin : g_r
      assign rmap[r] = rng[r - IR];
    end else if (r == `UIC_IX(`UIC_A_QRNG)) begin : g_q
      assign rmap[r] = qrng;
    end else if (r >= IV && r < IV + NCH) begin : g_v
      assign rmap[r] = val[r - IV];
    end else if (r == `UIC_IX(`UIC_A_QCNT)) begin : g_n
      assign rmap[r] = {{16{qcnt[15]}}, qcnt};
    end else if (r == `UIC_IX(`UIC_A_DIG)) begin : g_d
      assign rmap[r] = {25'h0000000, dig_state};
    end else if (r == `UIC_IX(`UIC_A_FLT)) begin : g_f
      assign rmap[r] = {28'h0000000, fault};
    end else if (r >= IS && r < IS + 4 && (r - IS) % 2 == 0) begin : g_sa
      assign rmap[r] = {4'h0, s_sig2[r - IS + 1], 4'h0, s_sig1[r - IS + 1]};
    end else if (r >= IS && r < IS + 4) begin : g_sb
      assign rmap[r] = {12'h000, s_stat[r - IS], s_crc[r - IS]};
    end else begin : g_z
      assign rmap[r] = 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // shared time bases
  // ------------------------------------------------------------
  logic [31:0] ms_cnt;
  logic [7:0] us_cnt;
  wire ms_tick = ms_cnt == 32'(MS_CYCLES - 1);
  wire us_tick = us_cnt == 8'(`UIC_TMR_CYC - 1);

  always_ff @(posedge mclk) begin
    if (srst) begin
      ms_cnt <= 32'h0000_0000;
      us_cnt <= 8'h00;
    end else begin
      ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
      us_cnt <= us_tick ? 8'h00 : us_cnt + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // digital path, four universal then three pulse pins
  // ------------------------------------------------------------
  wire [6:0] pins = {pulse_pin, uin_pin};

  for (genvar k = 0; k < NDI; k++) begin : g_dig
    logic stab, prev, lat;
    logic [9:0] dcnt;
    wire [7:0] t = cfg[k][7:0];
    wire act = pins[k] ^ cfg[k][`UIC_POL_BIT];
    wire [9:0] dtgt = db_ms(cfg[k][10:8]);
    wire [1:0] pull = cfg[k][14:13];
    wire uni = (k < NCH);
    uic_mode_t md;
    assign md = mode_of(t, 1'b0);
    // pulse pins have no capture path, so only digital and quadrature use pulls
    wire pull_ok = uni ? (md == md_freq || md == md_pwm || md == md_dig)
                       : (md == md_dig || t == `UIC_T_QD);

    always_ff @(posedge mclk) begin
      if (srst) begin
        stab <= 1'b0;
        prev <= 1'b0;
        lat <= 1'b0;
        dcnt <= 10'h000;
      end else begin
        // granularity is one ms tick, so a level may be taken up to one tick early
        if (act == stab) begin
          dcnt <= 10'h000;
        end else if (dcnt >= dtgt) begin
          stab <= act;
          dcnt <= 10'h000;
        end else if (ms_tick) begin
          dcnt <= dcnt + 10'h001;
        end
        prev <= stab;
        if (stab & ~prev) begin
          lat <= ~lat;
        end
      end
    end

    assign dig_state[k] = (t == `UIC_T_DN) ? stab :
                          (t == `UIC_T_DI) ? ~stab :
                          (t == `UIC_T_DL) ? lat : 1'b0;
    assign pull_up_en[k] = pull_ok & (pull == `UIC_PULL_UP);
    assign pull_dn_en[k] = pull_ok & (pull == `UIC_PULL_DN);
  end

  // ------------------------------------------------------------
  // universal measurement channels
  // ------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    uic_mode_t md;
    logic gq, gprev, cap;
    logic [10:0] gcnt;
    logic [15:0] pcnt, hcnt, per, wid;
    assign md = mode_of(cfg[i][7:0], (i == 1) || (i == 3));
    wire [10:0] gtgt = gf_cyc(cfg[i][12:11]);

    always_ff @(posedge mclk) begin
      if (srst) begin
        gq <= 1'b0;
        gcnt <= 11'h000;
      end else if (uin_pin[i] == gq) begin
        gcnt <= 11'h000;
      end else if (gcnt >= gtgt) begin
        gq <= uin_pin[i];
        gcnt <= 11'h000;
      end else begin
        gcnt <= gcnt + 11'h001;
      end
    end

    // 1 us counts saturate, so the slowest ranges pin at full scale
    always_ff @(posedge mclk) begin
      if (srst) begin
        gprev <= 1'b0;
        cap <= 1'b0;
        pcnt <= 16'h0000;
        hcnt <= 16'h0000;
        per <= 16'h0000;
        wid <= 16'h0000;
      end else begin
        gprev <= gq;
        cap <= 1'b0;
        if (us_tick) begin
          if (pcnt != 16'hffff) pcnt <= pcnt + 16'h0001;
          if (gq && hcnt != 16'hffff) hcnt <= hcnt + 16'h0001;
        end
        if (gq & ~gprev) begin
          per <= pcnt;
          // a tick on the capture edge opens the new period, else counts drift by one
          pcnt <= 16'(us_tick);
          hcnt <= 16'(us_tick);
          cap <= (md == md_freq);
        end
        if (~gq & gprev) begin
          wid <= hcnt;
          cap <= (md == md_pwm);
        end
      end
    end

    wire [15:0] raw = (md == md_ana) ? {4'h0, adc_data[12*i +: 12]} :
                      (md == md_freq) ? per :
                      (md == md_pwm) ? wid :
                      (md == md_sent) ? {4'h0, s_sig1[i]} : 16'h0000;
    wire smp = (md == md_ana) ? adc_valid[i] :
               (md == md_freq || md == md_pwm) ? cap :
               (md == md_sent) ? s_done[i] : 1'b0;
    wire [31:0] scl = (ppr[i] != 16'h0000) ? ({16'h0000, raw} * {16'h0000, ppr[i]})
                                           : {16'h0000, raw};
    wire [31:0] mn = {16'h0000, rng[i][15:0]};
    wire [31:0] mx = {16'h0000, rng[i][31:16]};
    wire [15:0] sat = (scl < mn) ? mn[15:0] : (scl > mx) ? mx[15:0] : scl[15:0];

    uic_filt_if fif ();
    assign fif.valid = smp;
    assign fif.din = sat;
    assign fif.ftype = cfg[i][17:16];
    assign fif.fconst = cfg[i][31:24];
    uic_filter u_filt (
      .mclk(mclk),
      .srst(srst),
      .f(fif)
    );

    assign val[i] = (md == md_dig) ? {31'h00000000, dig_state[i]} :
                    (md == md_off) ? 32'h0000_0000 : {16'h0000, fif.dout};
    assign fault[i] = (md != md_dig) && (md != md_off) && ((scl < mn) || (scl > mx));

    if (i == 1 || i == 3) begin : g_sent
      uic_sent_st_t st;
      logic sprev, done;
      logic [8:0] pc;
      logic [7:0] tk;
      logic [2:0] n;
      logic [3:0] crc, stt, rstat;
      logic [23:0] dat;
      logic [11:0] sig1, sig2;
      logic [15:0] crcs;
      wire fall = sprev & ~uin_pin[i];
      wire is_sync = (tk >= `UIC_S_SYNC - 8'h01) && (tk <= `UIC_S_SYNC + 8'h01);
      wire is_nib = (tk >= `UIC_S_NIB0) && (tk <= `UIC_S_NIBF);
      wire [3:0] nib = 4'(tk - `UIC_S_NIB0);

      always_ff @(posedge mclk) begin
        if (srst) begin
          st <= st_hunt;
          sprev <= 1'b0;
          done <= 1'b0;
          pc <= 9'h000;
          tk <= 8'h00;
          n <= 3'h0;
          crc <= 4'h0;
          stt <= 4'h0;
          rstat <= 4'h0;
          dat <= 24'h000000;
          sig1 <= 12'h000;
          sig2 <= 12'h000;
          crcs <= 16'h0000;
        end else begin
          sprev <= uin_pin[i];
          done <= 1'b0;
          // half-tick start rounds each interval to the nearest tick
          if (fall) begin
            pc <= 9'(`UIC_TICK_CYC / 2);
            tk <= 8'h00;
          end else if (pc == 9'(`UIC_TICK_CYC - 1)) begin
            pc <= 9'h000;
            if (tk != 8'hff) tk <= tk + 8'h01;
          end else begin
            pc <= pc + 9'h001;
          end
          if (fall) begin
            case (st)
              st_hunt: begin
                if (is_sync) begin
                  st <= st_nib;
                  n <= 3'h0;
                  crc <= `UIC_S_SEED;
                end
              end
              st_nib: begin
                if (is_sync) begin
                  n <= 3'h0;
                  crc <= `UIC_S_SEED;
                end else if (!is_nib) begin
                  st <= st_hunt;
                end else begin
                  n <= n + 3'h1;
                  if (n == 3'h0) begin
                    stt <= nib;
                  end else if (n != 3'h7) begin
                    dat <= {dat[19:0], nib};
                    crc <= crc4(crc, nib);
                  end else begin
                    rstat <= stt;
                    sig1 <= dat[23:12];
                    sig2 <= dat[11:0];
                    crcs <= {4'h0, nib, 4'h0, crc};
                    done <= 1'b1;
                    st <= st_hunt;
                  end
                end
              end
              default: st <= st_hunt;
            endcase
          end
        end
      end

      assign s_done[i] = done;
      assign s_stat[i] = rstat;
      assign s_sig1[i] = sig1;
      assign s_sig2[i] = sig2;
      assign s_crc[i] = crcs;
    end else begin : g_nosent
      assign s_done[i] = 1'b0;
      assign s_stat[i] = 4'h0;
      assign s_sig1[i] = 12'h000;
      assign s_sig2[i] = 12'h000;
      assign s_crc[i] = 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // quadrature counter on pulse pins one and two
  // ------------------------------------------------------------
  logic [1:0] qa, qb;
  logic as_q, bs_q, pa, pb;
  wire qen = (cfg[4][7:0] == `UIC_T_QD) && (cfg[5][7:0] == `UIC_T_QD);
  wire qmove = (as_q != pa) || (bs_q != pb);
  wire up = pa ~^ bs_q;
  wire signed [15:0] qmin = $signed(qrng[15:0]);
  wire signed [15:0] qmax = $signed(qrng[31:16]);

  always_ff @(posedge mclk) begin
    if (srst) begin
      qa <= 2'h0;
      qb <= 2'h0;
      as_q <= 1'b0;
      bs_q <= 1'b0;
      pa <= 1'b0;
      pb <= 1'b0;
      qcnt <= 16'sh0000;
    end else begin
      qa <= {qa[0], pulse_pin[0]};
      qb <= {qb[0], pulse_pin[1]};
      // a level counts only after two equal samples
      if (qa[1] == qa[0]) as_q <= qa[1];
      if (qb[1] == qb[0]) bs_q <= qb[1];
      pa <= as_q;
      pb <= bs_q;
      if (!qen) begin
        qcnt <= 16'sh0000;
      end else if (qcnt > qmax) begin
        qcnt <= qmax;
      end else if (qcnt < qmin) begin
        qcnt <= qmin;
      end else if (qmove && up && qcnt < qmax) begin
        qcnt <= qcnt + 16'sh0001;
      end else if (qmove && !up && qcnt > qmin) begin
        qcnt <= qcnt - 16'sh0001;
      end
    end
  end
endmodule : uic_top

/* tb/uic_top_assertions.sv */
module uic_top_assertions (
  // clock and bus
  input wire logic mclk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pin side
  input wire logic [6:0] pull_up_en,
  input wire logic [6:0] pull_dn_en,
  input wire logic [6:0] dig_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("stray ack");
  a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("data moved");
  a_hole_zero: assert property (s_req ##0 (!wb_we_i && wb_adr_i[7]) |=> wb_dat_o == 32'h0)
    else $error("hole read");
  a_pull_excl: assert property ((pull_up_en & pull_dn_en) == 7'h0)
    else $error("pull clash");
  a_pull_rst: assert property (disable iff (1'b0) srst |=> (pull_up_en | pull_dn_en) == 7'h0)
    else $error("pull after reset");
  a_dig_rst: assert property (disable iff (1'b0) srst |=> dig_state == 7'h0)
    else $error("state after reset");
endmodule : uic_top_assertions
bind uic_top uic_top_assertions uic_top_assertions_i (.mclk(mclk), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pull_up_en(pull_up_en),
  .pull_dn_en(pull_dn_en), .dig_state(dig_state));

/* tb/uic_sensor_model.sv */
module uic_sensor_model (
  // pulls from the block
  input wire logic [6:0] pull_up_en,
  input wire logic [6:0] pull_dn_en,
  // bench control
  input wire logic [6:0] drv_en,
  input wire logic [6:0] drv_lvl,
  // sensor pins
  output logic [3:0] uin_pin,
  output logic [2:0] pulse_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] pin;
  // released and unpulled: inverse of last level, so no lucky reads
  assign pin = (drv_en & drv_lvl) | (~drv_en & (pull_up_en | (~pull_dn_en & ~drv_lvl)));
  assign uin_pin = pin[3:0];
  assign pulse_pin = pin[6:4];
endmodule : uic_sensor_model

/* tb/uic_top_tb.sv */
module uic_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, srst, cs, we, ack;
  logic [7:0] adr;
  logic [31:0] wd, dout;
  logic [47:0] adc;
  logic [3:0] av, up;
  logic [2:0] pp;
  logic [6:0] pu, pd, dig, den, dlv;
  int err_count, checked;
  // ------
  // block and sensors
  // ------
  uic_top #(.MS_CYCLES(10)) uic_top_i (.mclk(mclk), .srst(srst), .wb_cyc_i(cs), .wb_stb_i(cs),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(dout), .wb_ack_o(ack),
    .adc_data(adc), .adc_valid(av), .uin_pin(up), .pulse_pin(pp), .pull_up_en(pu),
    .pull_dn_en(pd), .dig_state(dig));
  uic_sensor_model uic_sensor_model_i (.pull_up_en(pu), .pull_dn_en(pd), .drv_en(den),
    .drv_lvl(dlv), .uin_pin(up), .pulse_pin(pp));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ------
  // tasks
  // ------
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    checked++;
    if (v !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", s, e, v);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input string s = "");
    wt(1);
    cs <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      wt(1);
    end while (ack !== 1'b1);
    if (!w) chk(s, d, dout);
    cs <= 1'b0;
  endtask : bus
  task automatic smp(input logic [11:0] v, input logic [31:0] e, input string s);
    adc <= {36'h0, v};
    av <= 4'h1;
    wt(1);
    av <= 4'h0;
    bus(1'b0, 8'h50, e, s);
  endtask : smp
  task automatic t_ana();
    bus(1'b0, 8'h00, 32'h4000, "cfg");
    bus(1'b0, 8'h80, 32'h0, "hole");
    bus(1'b1, 8'h00, 32'h400c);
    smp(12'habc, 32'habc, "volt");
    bus(1'b1, 8'h30, 32'h0100_0010);
    smp(12'h200, 32'h100, "sat hi");
    smp(12'h004, 32'h10, "sat lo");
    bus(1'b1, 8'h20, 32'h3);
    smp(12'h020, 32'h60, "rpm");
    bus(1'b1, 8'h00, 32'h0201_400c);
    smp(12'h040, 32'h90, "mov");
    bus(1'b1, 8'h00, 32'h0202_400c);
    smp(12'h010, 32'h90, "rep 1");
    smp(12'h020, 32'h48, "rep 2");
  endtask : t_ana
  task automatic t_dig();
    logic [31:0] c [3] = '{32'h403d, 32'h403c, 32'hc03c};
    dlv[0] <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h00, c[i]);
      wt(20);
      chk("dig", i == 1, dig[0]);
    end
    bus(1'b1, 8'h08, 32'h403e);
    for (int i = 0; i < 3; i++) begin
      dlv[2] <= ~i[0];
      wt(20);
      chk("latch", i < 2, dig[2]);
    end
    den[0] <= 1'b0;
    dlv[0] <= 1'b0;
    wt(20);
    chk("pull dn", 32'h3, {dig[0], pd[0]});
    bus(1'b1, 8'h00, 32'ha03c);
    wt(20);
    chk("pull up", 32'h1, {dig[0], pu[0]});
    bus(1'b1, 8'h18, 32'h413c);
    dlv[6] <= 1'b1;
    wt(60);
    chk("bounce", 0, dig[6]);
    wt(80);
    chk("bounce", 1, dig[6]);
    bus(1'b0, 8'h68, 32'h0, "fault");
  endtask : t_dig
  task automatic qrun(input bit rev);
    logic [1:0] q [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    for (int i = 0; i < 4; i++) begin
      dlv[5:4] <= q[rev ? (2 - i) & 3 : i];
      wt(10);
    end
  endtask : qrun
  task automatic t_quad();
    bus(1'b1, 8'h10, 32'h4050);
    bus(1'b1, 8'h14, 32'h4050);
    qrun(1'b0);
    bus(1'b0, 8'h60, 32'h4, "fwd");
    qrun(1'b1);
    bus(1'b0, 8'h60, 32'h0, "rev");
    bus(1'b1, 8'h40, 32'h0002_0000);
    qrun(1'b0);
    bus(1'b0, 8'h60, 32'h2, "clamp");
  endtask : t_quad
  task automatic t_cap();
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, 8'h0c, j ? 32'h4832 : 32'h4828);
      repeat (3) begin
        dlv[3] <= 1'b1;
        wt(500);
        dlv[3] <= 1'b0;
        wt(200);
        dlv[3] <= 1'b1;
        wt(5);
        dlv[3] <= 1'b0;
        wt(295);
      end
      bus(1'b0, 8'h5c, 32'ha >> j, "cap");
    end
  endtask : t_cap
  task automatic t_sent();
    int tk [10] = '{5, 56, 16, 13, 14, 15, 12, 12, 12, 22};
    bus(1'b1, 8'h04, 32'h4064);
    dlv[1] <= 1'b1;
    foreach (tk[j]) begin
      wt(tk[j] * 300 - 30);
      dlv[1] <= 1'b0;
      wt(30);
      dlv[1] <= 1'b1;
    end
    bus(1'b0, 8'h70, 32'h123, "sent a");
    bus(1'b0, 8'h74, 32'h4_0a0a, "sent b");
    bus(1'b0, 8'h54, 32'h123, "sent val");
  endtask : t_sent
  task automatic final_report();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    {cs, we, adr, wd, adc, av, dlv} = '0;
    srst = 1'b1;
    den = 7'h7f;
    wt(8);
    srst <= 1'b0;
    t_ana();
    t_dig();
    t_quad();
    t_cap();
    t_sent();
    final_report();
  end
  initial begin
    wt(80000);
    err_count++;
    final_report();
  end
endmodule : uic_top_tb
